// ### regbank.sv
`timescale 1ns/100ps
module regbank (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic soft_rst,
  input regbank_pkg::bus_req_s req,
  input wire logic [regbank_pkg::DW-1:0] status_in,
  input wire logic [regbank_pkg::DW-1:0] flag_events,
  output logic [regbank_pkg::DW-1:0] rdata,
  output logic rvalid,
  output logic [regbank_pkg::DW-1:0] ctrl,
  output logic [regbank_pkg::DW-1:0] flags,
  output logic [regbank_pkg::DW-1:0] cmd_data,
  output logic cmd_strobe,
  output logic [regbank_pkg::DW-1:0] debug_ctrl
);
  logic [regbank_pkg::DW-1:0] next_ctrl, next_flags, next_cmd_data, next_debug_ctrl, next_rdata;
  logic next_cmd_strobe, next_rvalid;
  logic [regbank_pkg::DW-1:0] status_meta, status_sync;

  function automatic logic hit(input regbank_pkg::bus_req_s r, input logic [regbank_pkg::AW-1:0] a);
    hit = r.wr && (r.addr == a);
  endfunction : hit

  // Live status comes from another domain
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      status_meta <= regbank_pkg::ZERO;
      status_sync <= regbank_pkg::ZERO;
    end else begin
      status_meta <= status_in;
      status_sync <= status_meta;
    end
  end

  always_comb begin
    logic [regbank_pkg::DW-1:0] set_m, clr_m, sts;
    set_m = regbank_pkg::ZERO;
    clr_m = regbank_pkg::ZERO;
    sts = status_sync & regbank_pkg::STATUS_MASK;
    // Reserved mode code is never reported
    if (sts[regbank_pkg::MODE_LSB +: 2] == regbank_pkg::MODE_RESERVED) begin
      sts[regbank_pkg::MODE_LSB +: 2] = regbank_pkg::MODE_FALLBACK;
    end
    next_ctrl = ctrl;
    next_flags = flags;
    next_cmd_data = cmd_data;
    next_debug_ctrl = debug_ctrl;
    next_cmd_strobe = 1'b0;
    next_rvalid = req.rd;
    next_rdata = regbank_pkg::ZERO;
    if (hit(req, regbank_pkg::ADDR_CTRL)) begin
      next_ctrl = req.wdata & regbank_pkg::CTRL_MASK;
    end
    // Status address ignores writes
    if (hit(req, regbank_pkg::ADDR_CMD)) begin
      next_cmd_data = req.wdata;
      next_cmd_strobe = 1'b1;
    end
    if (hit(req, regbank_pkg::ADDR_FLAGS_SET)) begin
      set_m = req.wdata;
    end
    if (hit(req, regbank_pkg::ADDR_FLAGS_CLR)) begin
      clr_m = req.wdata;
    end
    if (hit(req, regbank_pkg::ADDR_DEBUG)) begin
      next_debug_ctrl = req.wdata & regbank_pkg::DEBUG_MASK;
    end
    // Zero bits pass through; clear applied last so it wins
    next_flags = ((flags | set_m | flag_events) & ~clr_m) & regbank_pkg::FLAGS_MASK;
    case (req.addr)
      regbank_pkg::ADDR_CTRL: next_rdata = ctrl;
      regbank_pkg::ADDR_STATUS: next_rdata = sts;
      regbank_pkg::ADDR_FLAGS_SET: next_rdata = flags;
      regbank_pkg::ADDR_FLAGS_CLR: next_rdata = flags;
      regbank_pkg::ADDR_DEBUG: next_rdata = debug_ctrl;
      // Command is write-only; reads give zero, not to be relied on
      regbank_pkg::ADDR_CMD: next_rdata = regbank_pkg::ZERO;
      default: next_rdata = regbank_pkg::ZERO;
    endcase
    if (!req.rd) begin
      next_rdata = regbank_pkg::ZERO;
    end
    if (soft_rst) begin
      // Debug control survives a peripheral reset
      next_ctrl = regbank_pkg::CTRL_RESET;
      next_flags = regbank_pkg::FLAGS_RESET;
      next_cmd_data = regbank_pkg::ZERO;
      next_cmd_strobe = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl <= regbank_pkg::CTRL_RESET;
      flags <= regbank_pkg::FLAGS_RESET;
      cmd_data <= regbank_pkg::ZERO;
      cmd_strobe <= 1'b0;
      debug_ctrl <= regbank_pkg::DEBUG_RESET;
      rdata <= regbank_pkg::ZERO;
      rvalid <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      flags <= next_flags;
      cmd_data <= next_cmd_data;
      cmd_strobe <= next_cmd_strobe;
      debug_ctrl <= next_debug_ctrl;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end
endmodule : regbank

// ### regbank_pkg.sv
// Summary of operation
// - Read/write bits return the stored value and take written values.
// - Read-only bits return live value; writes leave them unchanged.
// - Write-only bits accept writes; reads return no dependable value.
// - Reserved bit positions always read back as zero.
// - Read-only multi-bit fields only ever report defined encodings.
// - Power-on reset restores all reset values; peripheral software reset restores all except debug control.
// - Writing one to a clear-register bit clears the shared bit.
// - Writing one to a set-register bit sets the shared bit.
// - Both registers of a set/clear pair read the same value.
// - Simultaneous set and clear writes: clear wins per bit.
package regbank_pkg;
  localparam int DW = 8;
  localparam int AW = 3;
  // Register indices
  localparam logic [AW-1:0] ADDR_CTRL = 3'h0;
  localparam logic [AW-1:0] ADDR_STATUS = 3'h1;
  localparam logic [AW-1:0] ADDR_CMD = 3'h2;
  localparam logic [AW-1:0] ADDR_FLAGS_SET = 3'h3;
  localparam logic [AW-1:0] ADDR_FLAGS_CLR = 3'h4;
  localparam logic [AW-1:0] ADDR_DEBUG = 3'h5;
  // Implemented-bit masks; zero bits are reserved
  localparam logic [DW-1:0] CTRL_MASK = 8'h3F;
  localparam logic [DW-1:0] STATUS_MASK = 8'h3F;
  localparam logic [DW-1:0] DEBUG_MASK = 8'h01;
  localparam logic [DW-1:0] FLAGS_MASK = 8'hFF;
  localparam logic [DW-1:0] CTRL_RESET = 8'h00;
  localparam logic [DW-1:0] FLAGS_RESET = 8'h00;
  localparam logic [DW-1:0] DEBUG_RESET = 8'h00;
  // Two-bit mode field in status[5:4]; encoding 3 is reserved
  localparam int MODE_LSB = 4;
  localparam logic [1:0] MODE_RESERVED = 2'h3;
  localparam logic [1:0] MODE_FALLBACK = 2'h0;
  localparam logic [DW-1:0] ZERO = 8'h00;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } bus_req_s;
endpackage : regbank_pkg

// ### regbank_monitor.sv
`timescale 1ns/100ps
module regbank_monitor (input wire logic clk_sys, sys_rst, soft_rst, input regbank_pkg::bus_req_s req,
  input wire logic [7:0] status_in, flag_events, rdata, ctrl, flags, cmd_data, debug_ctrl,
  input wire logic rvalid, cmd_strobe);
  wire [7:0] s = (req.wr && req.addr == 3'h3) ? req.wdata : 8'h00;
  wire [7:0] c = (req.wr && req.addr == 3'h4) ? req.wdata : 8'h00;
  wire w = req.wr && !soft_rst;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_ctrl_rsvd_zero: assert property (ctrl[7:6] == 2'h0) else $error("ctrl rsvd");
  a_dbg_rsvd_zero: assert property (debug_ctrl[7:1] == 7'h00) else $error("dbg rsvd");
  a_ctrl_write: assert property (w && req.addr == 3'h0 |=> ctrl == ($past(req.wdata) & 8'h3F)) else $error("ctrl");
  a_flags_next: assert property (!soft_rst |=> flags == (($past(flags) | $past(s) | $past(flag_events)) & ~$past(c)))
    else $error("flags");
  a_pair_read: assert property (req.rd && req.addr inside {3'h3, 3'h4} |=> rvalid && rdata == $past(flags))
    else $error("pair rd");
  a_status_defined: assert property (rvalid && $past(req.addr) == 3'h1 |-> rdata[5:4] != 2'h3 && rdata[7:6] == 2'h0)
    else $error("status");
  a_soft_clears: assert property (soft_rst |=> ctrl == 8'h00 && flags == 8'h00 && cmd_data == 8'h00 && !cmd_strobe)
    else $error("soft rst");
  a_debug_kept: assert property (soft_rst && !(req.wr && req.addr == 3'h5) |=> $stable(debug_ctrl)) else $error("dbg");
  a_cmd_taken: assert property (w && req.addr == 3'h2 |=> cmd_strobe && cmd_data == $past(req.wdata)) else $error("cmd");
  c_clr_vs_event: cover property (|(c & flag_events));
  c_soft: cover property (soft_rst);
  c_read: cover property (rvalid);
endmodule : regbank_monitor
bind regbank regbank_monitor i_regbank_monitor (.*);

// ### register_access_conventions_bench.sv
`timescale 1ns/100ps
module register_access_conventions_bench;
  logic clk_sys = 0, sys_rst = 1, soft_rst = 0, rvalid, cmd_strobe, ev, es;
  logic [7:0] s1 = 0, s2 = 0;
  regbank_pkg::bus_req_s req = '0;
  logic [7:0] status_in = 0, flag_events = 0, rdata, ctrl, flags, cmd_data, debug_ctrl, ec, ef, ed, em, er;
  int num_errors = 0, num_checks = 0, cyc = 0;
  always #5 clk_sys = ~clk_sys;
  regbank i_regbank (.*);
  // Status is masked; the reserved mode code 3 reads as mode 0
  function automatic logic [7:0] sts_exp(logic [7:0] v);
    logic [7:0] m;
    m = v & 8'h3F;
    if (m[5:4] == 2'h3) m[5:4] = 2'h0;
    return m;
  endfunction : sts_exp
  function automatic logic [7:0] rd_exp(logic [2:0] a);
    return a == 3'h0 ? ec : a == 3'h1 ? sts_exp(s2) : (a == 3'h3 || a == 3'h4) ? ef : a == 3'h5 ? ed : 8'h00;
  endfunction : rd_exp
  task automatic chk(logic [23:0] got, logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict;
    if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 3000) begin
      num_errors++;
      print_verdict;
    end else if (sys_rst) begin
      {ec, ef, ed, em, er, es, ev} = '0;
      {s1, s2} = '0;
    end else begin
      er = req.rd ? rd_exp(req.addr) : 8'h00;
      ev = req.rd;
      // Two-stage status synchroniser
      s2 = s1;
      s1 = status_in;
      es = req.wr && req.addr == 3'h2 && !soft_rst;
      if (req.wr && req.addr == 3'h5) ed = req.wdata & 8'h01;
      if (soft_rst) {ec, ef, em} = '0;
      else begin
        if (req.wr && req.addr == 3'h0) ec = req.wdata & 8'h3F;
        if (es) em = req.wdata;
        ef = (ef | flag_events | (req.wr && req.addr == 3'h3 ? req.wdata : 8'h00))
          & ~(req.wr && req.addr == 3'h4 ? req.wdata : 8'h00);
      end
    end
  end
  initial begin
    void'($urandom(52));
    repeat (2) @(negedge clk_sys);
    sys_rst = 0;
    for (int i = 0; i < 2000; i++) begin
      @(negedge clk_sys);
      chk({ctrl, flags, cmd_data}, {ec, ef, em});
      chk({cmd_strobe, rvalid, debug_ctrl}, {es, ev, ed});
      chk(rdata, er);
      req = 13'($urandom);
      // Random writes keep reserved bits at zero; corner cases below do not
      if (req.addr inside {3'h0, 3'h1}) req.wdata[7:6] = 2'h0;
      if (req.addr == 3'h5) req.wdata[7:1] = 7'h00;
      // No fuse bytes exist here, so none are ever written
      // Defined mode encodings only; reserved bits already zeroed above
      if (req.addr == 3'h0 && req.wdata[5:4] == 2'h3) req.wdata[5] = 0;
      if (i < 8) req = {2'b11, 3'(i), 8'hEF};
      flag_events = $urandom & $urandom & $urandom;
      status_in = $urandom;
      soft_rst = ($urandom % 16) == 0;
      sys_rst = i == 1000;
    end
    print_verdict;
  end
endmodule : register_access_conventions_bench
